// ===== src/scaler_filter_pkg.sv
// Shared constants and types for the scaler control and coefficient block
package scaler_filter_pkg;

    localparam int addr_width = 20;
    localparam int data_width = 32;

    // Register offsets, pipe A and pipe B instances
    localparam logic [19:0] a_window_size_offset = 20'h68074;
    localparam logic [19:0] a_control_offset     = 20'h68080;
    localparam logic [19:0] a_hluma_offset       = 20'h68100;
    localparam logic [19:0] a_hchroma_offset     = 20'h68200;
    localparam logic [19:0] a_vluma_offset       = 20'h68300;
    localparam logic [19:0] a_vchroma_offset     = 20'h68400;
    localparam logic [19:0] b_window_size_offset = 20'h68874;
    localparam logic [19:0] b_control_offset     = 20'h68880;
    localparam logic [19:0] b_hluma_offset       = 20'h68900;
    localparam logic [19:0] b_hchroma_offset     = 20'h68a00;
    localparam logic [19:0] b_vluma_offset       = 20'h68b00;
    localparam logic [19:0] b_vchroma_offset     = 20'h68c00;

    // Bank geometry
    localparam int phase_count  = 17;
    localparam int htap_count   = 7;
    localparam int vtap_count   = 5;
    localparam int hcenter_tap  = 3;
    localparam int vcenter_tap  = 2;
    localparam int hbank_words  = 60;
    localparam int vbank_words  = 43;
    localparam int bank_count   = 4;
    localparam int word_addr_w  = 6;

    // Control field positions and reset values
    localparam int ctrl_enable_bit    = 31;
    localparam int ctrl_adaptive_bit  = 27;
    localparam int ctrl_strength_lsb  = 25;
    localparam int ctrl_source_lsb    = 23;
    localparam int ctrl_prefilter_bit = 22;
    localparam logic [31:0] ctrl_reset     = 32'h00000000;
    localparam logic [31:0] ctrl_mask      = 32'h8fc00000;
    localparam logic [31:0] winsz_reset    = 32'h00000000;
    localparam logic [31:0] winsz_mask     = 32'h1fff0fff;
    localparam logic [31:0] coef_reset     = 32'h00000000;
    localparam logic [31:0] coef_word_mask = 32'hbff8bff8;

    // Coefficient field positions
    localparam int coef_sign_bit  = 15;
    localparam int coef_exp_lsb   = 12;
    localparam int coef_mant_lsb  = 3;
    localparam int coef_mant_w    = 9;
    localparam int coef_value_w   = 14;

    // Built-in 3x3 kernels, index 0 medium, 1 edge enhance, 2 edge soften
    localparam logic [15:0] builtin_center [3] =
        '{16'h1400, 16'h0280, 16'h1300};
    localparam logic [15:0] builtin_side [3] =
        '{16'h2400, 16'ha400, 16'h2600};

    typedef enum logic [1:0] {
        src_programmed   = 2'b00,
        src_medium       = 2'b01,
        src_edge_enhance = 2'b10,
        src_edge_soften  = 2'b11
    } coef_source_type;

    typedef enum logic [1:0] {
        adapt_least    = 2'b00,
        adapt_moderate = 2'b01,
        adapt_reserved = 2'b10,
        adapt_most     = 2'b11
    } strength_type;

    typedef enum logic [1:0] {
        bank_hluma   = 2'b00,
        bank_hchroma = 2'b01,
        bank_vluma   = 2'b10,
        bank_vchroma = 2'b11
    } bank_type;

    typedef struct packed {
        logic            scaler_enable;
        logic            adaptive_vfilter_enable;
        strength_type    adaptive_strength;
        coef_source_type coef_source;
        logic            chroma_prefilter_enable;
    } ctrl_type;

    typedef struct packed {
        bank_type   bank;
        logic [4:0] phase;
        logic [2:0] tap;
    } tap_req_type;

    typedef struct packed {
        logic                           sign;
        logic [1:0]                     exponent;
        logic [8:0]                     mantissa;
        logic signed [coef_value_w-1:0] value;
    } coef_type;

endpackage : scaler_filter_pkg

// ===== src/coef_mem.sv
// Coefficient word store with a write port and two registered read ports
module coef_mem
    import scaler_filter_pkg::*;
#(
    parameter int depth  = 60,
    parameter int width  = 32,
    parameter int aw     = 6
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             wr_en,
    input  wire logic [aw-1:0]    wr_addr,
    input  wire logic [width-1:0] wr_data,
    input  wire logic [aw-1:0]    rd_addr_a,
    input  wire logic [aw-1:0]    rd_addr_b,
    output logic      [width-1:0] rd_data_a_q,
    output logic      [width-1:0] rd_data_b_q
);

    logic [width-1:0] mem_q [depth];

    ////////////////////////////////////////////////////////////////////////
    // Storage; flops rather than RAM so every word clears at reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < depth; i++) begin
                mem_q[i] <= width'(coef_reset);
            end
        end else if (wr_en && (int'(wr_addr) < depth)) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered reads; out-of-range words read as zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_a_q <= '0;
            rd_data_b_q <= '0;
        end else begin
            rd_data_a_q <= (int'(rd_addr_a) < depth) ? mem_q[rd_addr_a] : '0;
            rd_data_b_q <= (int'(rd_addr_b) < depth) ? mem_q[rd_addr_b] : '0;
        end
    end

endmodule : coef_mem

// ===== src/scaler_filter_config.sv
// Scaler control register, double-buffered update and coefficient banks
module scaler_filter_config
    import scaler_filter_pkg::*;
#(
    parameter int          pix_width   = 24,
    parameter logic [19:0] winsz_base  = a_window_size_offset,
    parameter logic [19:0] ctrl_base   = a_control_offset,
    parameter logic [19:0] hluma_base  = a_hluma_offset,
    parameter logic [19:0] hchrom_base = a_hchroma_offset,
    parameter logic [19:0] vluma_base  = a_vluma_offset,
    parameter logic [19:0] vchrom_base = a_vchroma_offset
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [19:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    output logic      [31:0]           reg_rdata,
    output logic                       reg_rvalid,
    input  wire logic                  vblank_start,
    input  wire logic                  three_line_mode,
    input  wire logic [pix_width-1:0]  pix_in,
    input  wire logic                  pix_in_valid,
    input  wire logic [pix_width-1:0]  scaled_in,
    input  wire logic                  scaled_in_valid,
    output logic      [pix_width-1:0]  pix_out,
    output logic                       pix_out_valid,
    output ctrl_type                   active_ctrl,
    output logic                       update_armed,
    input  wire logic                  tap_req_valid,
    input  wire tap_req_type           tap_req,
    output logic                       tap_valid,
    output coef_type                   tap_coef
);

    localparam logic [19:0] bank_base [bank_count] =
        '{hluma_base, hchrom_base, vluma_base, vchrom_base};
    localparam int bank_depth [bank_count] =
        '{hbank_words, hbank_words, vbank_words, vbank_words};

    ////////////////////////////////////////////////////////////////////////
    // Address decoding shared by the write and read paths
    function automatic logic in_bank(input logic [19:0] addr,
                                     input logic [19:0] base,
                                     input int          depth);
        logic [19:0] limit;
        limit = base + 20'(depth * 4);
        return (addr >= base) && (addr < limit) && (addr[1:0] == 2'b00);
    endfunction : in_bank

    function automatic logic [word_addr_w-1:0] word_of(
        input logic [19:0] addr, input logic [19:0] base);
        logic [19:0] diff;
        diff = addr - base;
        return diff[word_addr_w+1:2];
    endfunction : word_of

    // Unpack one 16-bit coefficient into sign, exponent, mantissa, value
    function automatic coef_type decode(input logic [15:0] raw,
                                        input logic        center);
        coef_type                       c;
        logic     [8:0]                 mant;
        logic     [coef_value_w-2:0]    mag;
        c.sign     = raw[coef_sign_bit];
        c.exponent = raw[coef_exp_lsb+1:coef_exp_lsb];
        mant       = raw[coef_mant_lsb+coef_mant_w-1:coef_mant_lsb];
        if (!center) begin
            mant[1:0] = 2'b00;
        end
        c.mantissa = mant;
        // Value in units of 1/4096: mantissa is a 9-bit fraction
        case (c.exponent)
            2'b00:   mag = center ? {mant, 4'h0} : {4'h0, mant};
            2'b01:   mag = {1'b0, mant, 3'h0};
            2'b10:   mag = {2'h0, mant, 2'h0};
            2'b11:   mag = {3'h0, mant, 1'b0};
            default: mag = '0;
        endcase
        c.value = c.sign ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
        return c;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // Write and read strobes
    logic ctrl_wr;
    logic winsz_wr;
    logic [bank_count-1:0] bank_wr;
    logic [bank_count-1:0] bank_rd;

    assign ctrl_wr  = reg_wr && (reg_addr == ctrl_base);
    assign winsz_wr = reg_wr && (reg_addr == winsz_base);

    ////////////////////////////////////////////////////////////////////////
    // First-stage control and window size, both read back as written under ctrl_mask and winsz_mask
    logic [31:0] ctrl_stage_q;
    logic [31:0] winsz_q;
    logic        armed_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_stage_q <= ctrl_reset;
        end else if (ctrl_wr) begin
            ctrl_stage_q <= reg_wdata & ctrl_mask;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            winsz_q <= winsz_reset;
        end else if (winsz_wr) begin
            winsz_q <= reg_wdata & winsz_mask;
        end
    end

    // A window-size write arms; an arm landing on the blank edge survives
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= winsz_wr || (armed_q && !vblank_start);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Second stage: what the hardware actually runs on
    ctrl_type ctrl_q;
    ctrl_type ctrl_d;

    always_comb begin
        ctrl_d.scaler_enable           = ctrl_stage_q[ctrl_enable_bit];
        ctrl_d.adaptive_vfilter_enable = ctrl_stage_q[ctrl_adaptive_bit];
        // Reserved strength code runs as the recommended least setting
        case (ctrl_stage_q[ctrl_strength_lsb+1:ctrl_strength_lsb])
            2'b01:   ctrl_d.adaptive_strength = adapt_moderate;
            2'b11:   ctrl_d.adaptive_strength = adapt_most;
            default: ctrl_d.adaptive_strength = adapt_least;
        endcase
        ctrl_d.coef_source = coef_source_type'(
            ctrl_stage_q[ctrl_source_lsb+1:ctrl_source_lsb]);
        ctrl_d.chroma_prefilter_enable =
            ctrl_stage_q[ctrl_prefilter_bit];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= '0;
        end else if (vblank_start && armed_q) begin
            ctrl_q <= ctrl_d;
        end
    end

    assign active_ctrl  = ctrl_q;
    assign update_armed = armed_q;

    ////////////////////////////////////////////////////////////////////////
    // Pixel steering: around the scaler or through it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pix_out       <= '0;
            pix_out_valid <= 1'b0;
        end else if (ctrl_q.scaler_enable) begin
            pix_out       <= scaled_in;
            pix_out_valid <= scaled_in_valid;
        end else begin
            pix_out       <= pix_in;
            pix_out_valid <= pix_in_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tap lookup address: phase-major, two taps per word, low half first
    logic [7:0]             tap_index;
    logic [word_addr_w-1:0] tap_word;
    logic                   tap_is_h;
    logic [2:0]             tap_n;
    logic [2:0]             tap_center;
    logic                   tap_legal;

    always_comb begin
        tap_is_h   = (tap_req.bank == bank_hluma) ||
                     (tap_req.bank == bank_hchroma);
        tap_n      = tap_is_h ? 3'(htap_count) : 3'(vtap_count);
        tap_center = tap_is_h ? 3'(hcenter_tap) : 3'(vcenter_tap);
        tap_index  = 8'(tap_req.phase * tap_n) + 8'(tap_req.tap);
        tap_word   = tap_index[word_addr_w:1];
        tap_legal  = (tap_req.tap < tap_n) &&
                     (int'(tap_req.phase) < phase_count);
    end

    ////////////////////////////////////////////////////////////////////////
    // Coefficient banks, one write and one lookup per cycle each
    logic [31:0] rd_a [bank_count];
    logic [31:0] rd_b [bank_count];

    generate
        for (genvar b = 0; b < bank_count; b++) begin : g_bank
            assign bank_wr[b] = reg_wr &&
                                in_bank(reg_addr, bank_base[b], bank_depth[b]);
            assign bank_rd[b] = reg_rd &&
                                in_bank(reg_addr, bank_base[b], bank_depth[b]);
            coef_mem #(
                .depth (bank_depth[b]),
                .width (data_width),
                .aw    (word_addr_w)
            ) u_mem (
                .mclk        (mclk),
                .rst_b       (rst_b),
                .wr_en       (bank_wr[b]),
                .wr_addr     (word_of(reg_addr, bank_base[b])),
                .wr_data     (reg_wdata & coef_word_mask),
                .rd_addr_a   (word_of(reg_addr, bank_base[b])),
                .rd_addr_b   (tap_word),
                .rd_data_a_q (rd_a[b]),
                .rd_data_b_q (rd_b[b])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register read: one stage to the memories, one to the output
    logic                  rd1_q;
    logic [bank_count-1:0] rd1_bank_q;
    logic [31:0]           rd1_reg_q;
    logic [31:0]           rd_mux;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd1_q      <= 1'b0;
            rd1_bank_q <= '0;
            rd1_reg_q  <= '0;
        end else begin
            rd1_q      <= reg_rd;
            rd1_bank_q <= bank_rd;
            if (reg_addr == ctrl_base) begin
                rd1_reg_q <= ctrl_stage_q;
            end else if (reg_addr == winsz_base) begin
                rd1_reg_q <= winsz_q;
            end else begin
                rd1_reg_q <= '0;                 // Unmapped reads as zero
            end
        end
    end

    always_comb begin
        rd_mux = rd1_reg_q;
        for (int b = 0; b < bank_count; b++) begin
            if (rd1_bank_q[b]) begin
                rd_mux = rd_a[b];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= rd1_q ? rd_mux : '0;
            reg_rvalid <= rd1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tap lookup stage one: remember what the word will be used for
    logic     t1_valid_q;
    logic     t1_half_q;
    logic     t1_center_q;
    logic     t1_side_q;
    logic     t1_zero_q;
    bank_type t1_bank_q;
    logic     is_side;
    logic     unused_tap;

    always_comb begin
        // Three-line vertical mode keeps A, C, E; neighbours are two away
        unused_tap = !tap_is_h && three_line_mode &&
                     tap_req.tap[0];
        if (!tap_is_h && three_line_mode) begin
            is_side = (tap_req.tap == 3'd0) || (tap_req.tap == 3'd4);
        end else begin
            is_side = (tap_req.tap + 3'd1 == tap_center) ||
                      (tap_req.tap == tap_center + 3'd1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            t1_valid_q  <= 1'b0;
            t1_half_q   <= 1'b0;
            t1_center_q <= 1'b0;
            t1_side_q   <= 1'b0;
            t1_zero_q   <= 1'b0;
            t1_bank_q   <= bank_hluma;
        end else begin
            t1_valid_q  <= tap_req_valid;
            t1_half_q   <= tap_index[0];
            t1_center_q <= tap_req.tap == tap_center;
            t1_side_q   <= is_side;
            t1_zero_q   <= !tap_legal || unused_tap;
            t1_bank_q   <= tap_req.bank;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tap lookup stage two: pick half or built-in kernel and decode
    logic [31:0] t1_word;
    logic [15:0] t1_raw;
    logic [1:0]  kernel;

    always_comb begin
        t1_word = rd_b[t1_bank_q];
        kernel  = 2'(ctrl_q.coef_source) - 2'd1;
        case (ctrl_q.coef_source)
            src_programmed: begin
                t1_raw = t1_half_q ? t1_word[31:16] : t1_word[15:0];
            end
            src_medium, src_edge_enhance, src_edge_soften: begin
                if (t1_center_q) begin
                    t1_raw = builtin_center[kernel];
                end else if (t1_side_q) begin
                    t1_raw = builtin_side[kernel];
                end else begin
                    t1_raw = '0;
                end
            end
            default: t1_raw = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tap_valid <= 1'b0;
            tap_coef  <= '0;
        end else begin
            tap_valid <= t1_valid_q;
            tap_coef  <= t1_zero_q ? '0 :
                         decode(t1_raw, t1_center_q);
        end
    end

endmodule : scaler_filter_config

// ===== sim/scaler_filter_props.sv
// Checker for bus, arming, bypass and lookup timing of the scaler block
module scaler_filter_chk
    import scaler_filter_pkg::*;
#(
    parameter int          pix_width  = 24,
    parameter logic [19:0] winsz_base = a_window_size_offset
) (
    input wire logic                 mclk,
    input wire logic                 rst_b,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [19:0]          reg_addr,
    input wire logic                 reg_rvalid,
    input wire logic                 vblank_start,
    input wire logic [pix_width-1:0] pix_in,
    input wire logic                 pix_in_valid,
    input wire logic [pix_width-1:0] pix_out,
    input wire logic                 pix_out_valid,
    input wire ctrl_type             active_ctrl,
    input wire logic                 update_armed,
    input wire logic                 tap_req_valid,
    input wire logic                 tap_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // A size write in the load cycle keeps the transfer armed
    logic size_wr;
    assign size_wr = reg_wr && reg_addr == winsz_base;
    sequence armed_vblank;
        update_armed && vblank_start;
    endsequence
    sequence plain_load;
        armed_vblank ##0 !size_wr;
    endsequence
    chk_read_latency: assert property (reg_rd |-> ##2 reg_rvalid)
        else $error("read answer missing");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd, 2))
        else $error("read answer without request");
    chk_tap_latency: assert property (tap_req_valid |-> ##2 tap_valid)
        else $error("tap answer missing");
    chk_bypass_path: assert property (!active_ctrl.scaler_enable &&
        pix_in_valid |=> pix_out_valid && pix_out == $past(pix_in))
        else $error("bypass pixel wrong");
    chk_arm_by_size: assert property (size_wr |=> update_armed)
        else $error("size write did not arm");
    chk_unarmed_hold: assert property (vblank_start && !update_armed
        |=> $stable(active_ctrl)) else $error("unarmed load");
    chk_load_disarm: assert property (plain_load |=> !update_armed)
        else $error("arm flag not cleared");
    chk_change_cause: assert property (!$stable(active_ctrl)
        |-> $past(update_armed && vblank_start))
        else $error("control changed off vblank");
endmodule : scaler_filter_chk
////////////////////////////////////////////////////////////////////////////
bind scaler_filter_config scaler_filter_chk #(
    .pix_width(pix_width), .winsz_base(winsz_base)
) chk_u (
    .mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rvalid(reg_rvalid),
    .vblank_start(vblank_start), .pix_in(pix_in),
    .pix_in_valid(pix_in_valid), .pix_out(pix_out),
    .pix_out_valid(pix_out_valid), .active_ctrl(active_ctrl),
    .update_armed(update_armed), .tap_req_valid(tap_req_valid),
    .tap_valid(tap_valid)
);

// ===== sim/tb_top.sv
// Self-checking bench for the scaler control and coefficient block
module tb_top
    import scaler_filter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        vblank_start = 1'b0, three_line_mode = 1'b0;
    logic        pix_in_valid = 1'b0, scaled_in_valid = 1'b0;
    logic        tap_req_valid = 1'b0;
    logic [19:0] reg_addr = 20'h00000;
    logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
    logic [23:0] pix_in = 24'h000000, scaled_in = 24'h000000, pix_out;
    logic        reg_rvalid, pix_out_valid, update_armed, tap_valid;
    tap_req_type tap_req = '0;
    ctrl_type    active_ctrl;
    coef_type    tap_coef;
    int          err_count = 0, check_count = 0;
    always #10 mclk = ~mclk;
    scaler_filter_config dut_u (
        .mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .vblank_start(vblank_start),
        .three_line_mode(three_line_mode), .pix_in(pix_in),
        .pix_in_valid(pix_in_valid), .scaled_in(scaled_in),
        .scaled_in_valid(scaled_in_valid), .pix_out(pix_out),
        .pix_out_valid(pix_out_valid), .active_ctrl(active_ctrl),
        .update_armed(update_armed), .tap_req_valid(tap_req_valid),
        .tap_req(tap_req), .tap_valid(tap_valid), .tap_coef(tap_coef));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // A lost answer ends the run, later checks would be meaningless
    task automatic gate(logic f, string n);
        if (f !== 1'b1) begin
            err_count++;
            $display("Error %s expected 1 seen %b", n, f);
            give_verdict();
        end
    endtask : gate
    task automatic wr(logic [19:0] a, logic [31:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(logic [19:0] a, logic [31:0] e);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        for (int n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge mclk);
        gate(reg_rvalid, "reg_rvalid");
        cmp("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic tp(bank_type b, int p, int t, coef_type e);
        @(negedge mclk);
        tap_req_valid = 1'b1;
        tap_req = '{b, 5'(p), 3'(t)};
        @(negedge mclk);
        tap_req_valid = 1'b0;
        for (int n = 0; n < 4 && tap_valid !== 1'b1; n++) @(negedge mclk);
        gate(tap_valid, "tap_valid");
        cmp("tap_coef", 32'(e), 32'(tap_coef));
    endtask : tp
    task automatic vb;
        @(negedge mclk);
        vblank_start = 1'b1;
        @(negedge mclk);
        vblank_start = 1'b0;
    endtask : vb
    // Expected decode: side taps drop two mantissa bits, shift by exponent
    function automatic coef_type mk(logic [15:0] r, bit c);
        int sh;
        mk.sign = r[15];
        mk.exponent = r[13:12];
        mk.mantissa = c ? r[11:3] : {r[11:5], 2'b00};
        sh = (r[13:12] == 2'b00) ? (c ? 4 : 0) : 4 - int'(r[13:12]);
        mk.value = 14'(mk.mantissa) <<< sh;
        if (r[15]) mk.value = -mk.value;
    endfunction : mk
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] c;
        logic [6:0]  x;
        x = 7'h00;
        repeat (10) @(negedge mclk);
        rst_b = 1'b1;
        rd(a_control_offset, ctrl_reset);
        rd(a_vchroma_offset + 20'd168, coef_reset);
        wr(a_hchroma_offset + 20'd236, 32'hffffffff);
        rd(a_hchroma_offset + 20'd236, coef_word_mask);
        rd(20'h68000, 32'h00000000);
        $display("test registers done");
        wr(a_hluma_offset + 20'h00c, 32'h9ff82408);
        wr(a_hluma_offset + 20'h004, 32'h0ff80000);
        tp(bank_hluma, 1, 0, mk(16'h9ff8, 1'b0));
        tp(bank_hluma, 0, 6, mk(16'h2408, 1'b0));
        tp(bank_hluma, 0, 3, mk(16'h0ff8, 1'b1));
        tp(bank_hluma, 0, 7, mk(16'h0000, 1'b0));
        tp(bank_hchroma, 1, 0, mk(16'h0000, 1'b0));
        wr(a_hchroma_offset + 20'h00c, 32'h9ff82408);
        tp(bank_hchroma, 1, 0, mk(16'h9ff8, 1'b0));
        wr(a_vchroma_offset + 20'h008, 32'h30201020);
        wr(a_vchroma_offset, 32'h10201020);
        wr(a_vluma_offset + 20'h004, 32'h00000ff8);
        tp(bank_vchroma, 1, 0, mk(16'h3020, 1'b0));
        tp(bank_vchroma, 0, 4, mk(16'h1020, 1'b0));
        tp(bank_vluma, 0, 2, mk(16'h0ff8, 1'b1));
        three_line_mode = 1'b1;
        tp(bank_vchroma, 0, 1, mk(16'h0000, 1'b0));
        tp(bank_vchroma, 0, 0, mk(16'h1020, 1'b0));
        three_line_mode = 1'b0;
        $display("test coefficients done");
        for (int i = 0; i < 4; i++) begin
            c = {i[0], 4'hf, i[1], i[1] | i[0], i[1:0], i[0], 22'h3fffff};
            wr(a_control_offset, c);
            rd(a_control_offset, c & ctrl_mask);
            vb();
            cmp("active_ctrl", 32'(x), 32'(active_ctrl));
            wr(a_window_size_offset, 32'h01000100);
            cmp("update_armed", 32'h1, 32'(update_armed));
            vb();
            cmp("update_armed", 32'h0, 32'(update_armed));
            x = {i[0], 1'b1, i[1], i[1] | i[0], i[1:0], i[0]};
            cmp("active_ctrl", 32'(x), 32'(active_ctrl));
            pix_in = 24'h000100 + 24'(i);
            scaled_in = 24'h00a000 + 24'(i);
            // Only the selected stream is valid, so a wrong pick shows
            pix_in_valid = !x[6];
            scaled_in_valid = x[6];
            @(negedge mclk);
            cmp("pix_out", 32'(x[6] ? scaled_in : pix_in), 32'(pix_out));
            cmp("pix_out_valid", 32'h1, 32'(pix_out_valid));
            pix_in_valid = 1'b0;
            scaled_in_valid = 1'b0;
        end
        // Edge-soften kernel is active now: center, neighbour, far tap
        tp(bank_hluma, 0, 3, mk(builtin_center[2], 1'b1));
        tp(bank_hluma, 0, 4, mk(builtin_side[2], 1'b0));
        tp(bank_hluma, 0, 6, mk(16'h0000, 1'b0));
        wr(a_control_offset, 32'h04000000);
        wr(a_window_size_offset, 32'h01000100);
        vb();
        cmp("active_ctrl", 32'h0, 32'(active_ctrl));
        $display("test control done");
        give_verdict();
    end
endmodule : tb_top
